// ===== dv/lbpb_props.sv
// Port checks for the LED backlight and boost control top
`timescale 1ns/10ps
module lbpb_props #(
   parameter int unsigned RAMP_CYC = 8,
   parameter int unsigned DIM_CYC = 16
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic overvoltage_detect,
   input wire logic overcurrent_detect,
   input wire logic boost_switch_enable,
   input wire logic step_up_current_limit_sel,
   input wire logic step_up_switch_freq_sel,
   input wire logic string1_feedback_include,
   input wire logic string2_feedback_include,
   input wire logic string3_feedback_include,
   input wire logic string1_sink_enable,
   input wire logic string2_sink_enable,
   input wire logic string3_sink_enable,
   input wire logic interrupt_request_n
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire logic wr_boost = psel && penable && pready && pwrite && paddr == 12'h118;
   wire logic fault = overvoltage_detect || overcurrent_detect;
   ////////////////////////////////////////////////////////////////////////////////
   a_ready_wait: assert property ((psel && !penable) ##1 (psel && penable) |-> !pready ##1 pready)
      else $error("pready not after one wait state");
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held too long");
   a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0) else $error("prdata high set");
   a_err_unmapped: assert property (pready && (paddr[9:2] < 8'h46 || paddr[9:2] > 8'h4e) |-> pslverr)
      else $error("no error on unmapped address");
   a_boost_off: assert property (fault |-> !boost_switch_enable)
      else $error("boost runs during fault");
   a_ctrl_follow: assert property (wr_boost |=> step_up_current_limit_sel == $past(pwdata[4])
      && step_up_switch_freq_sel == $past(pwdata[5])) else $error("limit or frequency wrong");
   a_fb_needs_en: assert property ((!string1_feedback_include || string1_sink_enable)
      && (!string2_feedback_include || string2_sink_enable)
      && (!string3_feedback_include || string3_sink_enable)) else $error("feedback without sink");
   a_irq_fall: assert property ($fell(interrupt_request_n) |-> $past(fault || wr_boost))
      else $error("interrupt without fault");
   a_irq_rise: assert property ($rose(interrupt_request_n) |-> $past(wr_boost))
      else $error("interrupt released without write");
endmodule
bind lbpb_top lbpb_props #(.RAMP_CYC(RAMP_CYC), .DIM_CYC(DIM_CYC)) i_props (.mclk, .sys_rst,
   .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .overvoltage_detect,
   .overcurrent_detect, .boost_switch_enable, .step_up_current_limit_sel,
   .step_up_switch_freq_sel, .string1_feedback_include, .string2_feedback_include,
   .string3_feedback_include, .string1_sink_enable, .string2_sink_enable,
   .string3_sink_enable, .interrupt_request_n);

// ===== dv/lbpb_stage_model.sv
// Behavioural boost power stage and sink comparators that report faults on command
`timescale 1ns/10ps
module lbpb_stage_model (
   input wire logic mclk,
   input wire logic [1:0] fault_cmd,
   output logic overvoltage_detect,
   output logic overcurrent_detect
);
   initial begin
      overvoltage_detect = 1'b0;
      overcurrent_detect = 1'b0;
   end
   // Comparators are registered so a fault cannot loop through the switch enable
   always @(posedge mclk) begin
      overvoltage_detect <= fault_cmd[0];
      overcurrent_detect <= fault_cmd[1];
   end
endmodule

// ===== dv/tb_led_backlight_pwm_boost_ctrl.sv
// Self-checking bench for the LED backlight PWM and boost control block
`timescale 1ns/10ps
module tb_led_backlight_pwm_boost_ctrl;
   logic mclk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h0;
   logic [31:0] pwdata = 32'h0, prdata;
   logic [1:0] fcmd = 2'b00;
   logic pready, pslverr, overvoltage_detect, overcurrent_detect, boost_switch_enable;
   logic step_up_current_limit_sel, step_up_switch_freq_sel, interrupt_request_n;
   logic string1_feedback_include, string2_feedback_include, string3_feedback_include;
   logic string1_sink_enable, string2_sink_enable, string3_sink_enable;
   logic string1_sink_on, string2_sink_on, string3_sink_on;
   logic [7:0] string1_sink_code, string2_sink_code, string3_sink_code;
   int n_errors = 0, checks = 0, cyc = 0;
   always #12.5 mclk = ~mclk;
   // Dimming step is shortened to about two PWM periods so a three-step ramp ends within the run
   lbpb_top #(.RAMP_CYC(8), .DIM_CYC(4000)) i_dut (.mclk, .sys_rst, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .overvoltage_detect, .overcurrent_detect,
      .boost_switch_enable, .step_up_current_limit_sel, .step_up_switch_freq_sel,
      .string1_feedback_include, .string2_feedback_include, .string3_feedback_include,
      .string1_sink_enable, .string2_sink_enable, .string3_sink_enable, .string1_sink_on,
      .string2_sink_on, .string3_sink_on, .string1_sink_code, .string2_sink_code,
      .string3_sink_code, .interrupt_request_n);
   lbpb_stage_model i_stage (.mclk, .fault_cmd(fcmd), .overvoltage_detect, .overcurrent_detect);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      if (n_errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Called just after a rising edge; leaves one idle cycle so no signal is set twice at once
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
         output logic [31:0] rd, output logic err);
      int n;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) chk(0, 1, "pready");
      @(posedge mclk);
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
      logic [31:0] r;
      logic e;
      apb(1'b1, idx, wd, r, e);
   endtask
   task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] r;
      logic e;
      apb(1'b0, idx, 8'h0, r, e);
      chk(r, exp, "register");
      chk(e, 0, "register error");
   endtask
   // Counts on-cycles of a string over one full period and code errors meanwhile
   task automatic meas(input int s, input logic [7:0] c_on, input logic [7:0] c_off,
         output int on);
      logic o;
      logic [7:0] c;
      on = 0;
      repeat (3) @(posedge mclk);
      repeat (1900) begin
         @(posedge mclk);
         o = (s == 1) ? string1_sink_on : string3_sink_on;
         c = (s == 1) ? string1_sink_code : string3_sink_code;
         on += (o === 1'b1);
         if (c !== (o ? c_on : c_off)) chk(c, o ? c_on : c_off, "sink code");
      end
   endtask
   task automatic t_regs();
      logic [31:0] r;
      logic e;
      for (int i = 0; i < 9; i++) rdc(8'(8'h46 + i), i == 0 ? 32'h20 : i == 1 ? 32'h40 : 0);
      apb(1'b0, 8'h50, 8'h0, r, e);
      chk(r, 32'h0, "unmapped read data");
      chk(e, 1, "unmapped read");
      apb(1'b1, 8'h45, 8'hff, r, e);
      chk(e, 1, "unmapped write");
   endtask
   task automatic t_boost();
      wr(8'h47, 8'h55);
      wr(8'h46, 8'h1f);
      chk({boost_switch_enable, step_up_current_limit_sel, step_up_switch_freq_sel,
         string3_feedback_include, string2_feedback_include, string1_feedback_include},
         6'b110111, "boost outputs");
      wr(8'h47, 8'h54);
      rdc(8'h46, 32'h1d);
      fcmd <= 2'b01;
      repeat (2) @(posedge mclk);
      chk(boost_switch_enable, 0, "boost on overvoltage");
      fcmd <= 2'b00;
      repeat (2) @(posedge mclk);
      chk(interrupt_request_n, 0, "interrupt");
      wr(8'h46, 8'h1d);
      rdc(8'h46, 32'h9d);
      wr(8'h46, 8'h5d);
      chk(interrupt_request_n, 1, "masked interrupt");
      wr(8'h46, 8'hdd);
      rdc(8'h46, 32'h5d);
      fcmd <= 2'b10;
      repeat (2) @(posedge mclk);
      chk({boost_switch_enable, interrupt_request_n}, 2'b01, "overcurrent");
      fcmd <= 2'b00;
      rdc(8'h46, 32'hdd);
   endtask
   task automatic t_pwm();
      int on;
      wr(8'h47, 8'h41);
      wr(8'h48, 8'h05);
      wr(8'h49, 8'h80);
      wr(8'h4c, 8'd48);
      meas(1, 8'h80, 8'h05, on);
      chk(on, 48 * 20, "on time");
      chk({string3_sink_enable, string2_sink_enable, string1_sink_enable}, 3'b001, "sink enables");
      chk({string2_sink_on, string2_sink_code}, {1'b0, 8'h05}, "string 2 idle");
      wr(8'h4c, 8'h60);
      meas(1, 8'h80, 8'h05, on);
      chk(on, 1900, "full on");
      wr(8'h4c, 8'h00);
      meas(1, 8'h80, 8'h05, on);
      chk(on, 0, "off");
      wr(8'h4c, 8'h83);
      meas(1, 8'h80, 8'h05, on);
      chk(on < 60, 1, "dimming start");
      repeat (12000) @(posedge mclk);
      meas(1, 8'h80, 8'h05, on);
      chk(on, 60, "dimming end");
      wr(8'h47, 8'h43);
      wr(8'h4c, 8'h60);
      wr(8'h49, 8'h84);
      chk(string1_sink_code != 8'h84, 1, "ramp start");
      repeat (60) @(posedge mclk);
      chk(string1_sink_code, 8'h84, "ramp end");
      wr(8'h47, 8'h10);
      wr(8'h46, 8'h08);
      wr(8'h4e, 8'd95);
      meas(3, 8'h00, 8'h00, on);
      chk(on, 1900, "pwm only duty");
      chk({string3_sink_enable, string3_feedback_include}, 2'b00, "pwm only");
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         n_errors++;
         complete_run();
      end
   end
   initial begin
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      t_regs();
      t_boost();
      t_pwm();
      sys_rst <= 1'b1;
      repeat (2) @(posedge mclk);
      sys_rst <= 1'b0;
      @(posedge mclk);
      rdc(8'h46, 32'h20);
      complete_run();
   end
endmodule

// ===== rtl/lbpb_pkg.sv
// Shared constants for the LED backlight PWM and boost control block
package lbpb_pkg;

   // Clock and timing
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned STEP_HZ = 2_000_000;
   localparam int unsigned STEP_DIV = CLK_HZ / STEP_HZ;
   localparam int unsigned PWM_PERIOD = 95;
   localparam int unsigned CUR_RAMP_US = 1000;
   localparam int unsigned CUR_RAMP_CYC = CUR_RAMP_US * (CLK_HZ / 1_000_000);
   localparam int unsigned DIM_STEP_MS = 40;
   localparam int unsigned DIM_STEP_CYC = DIM_STEP_MS * 1000 * (CLK_HZ / 1_000_000);

   // Widths
   localparam int unsigned DUTY_W = 7;
   localparam int unsigned CODE_W = 8;
   localparam int unsigned PADDR_W = 12;

   // Register indexes; byte address is four times the index
   localparam logic [7:0] REG_BOOST = 8'h46;
   localparam logic [7:0] REG_LED_CONTROL = 8'h47;
   localparam logic [7:0] REG_IDLE_CURRENT = 8'h48;
   localparam logic [7:0] REG_STRING1_CURRENT = 8'h49;
   localparam logic [7:0] REG_STRING1_DUTY = 8'h4c;

   // Boost control fields
   localparam int unsigned BST_EN = 0;
   localparam int unsigned BST_FB1 = 1;
   localparam int unsigned BST_ILIM = 4;
   localparam int unsigned BST_FREQ = 5;
   localparam int unsigned BST_MASK = 6;
   localparam int unsigned BST_EVENT = 7;
   localparam logic [7:0] BOOST_RST = 8'h20;

   // LED control fields: enable at 2*n, ramp at 2*n+1, current mode of string 3 at 6
   localparam int unsigned LEDC_ICONT3 = 6;
   localparam logic [7:0] LED_CONTROL_RST = 8'h40;

   // Duty register: ratio in 6:0, dimming enable in 7
   localparam int unsigned DUTY_DIM = 7;
   localparam logic [7:0] CODE_RST = 8'h00;
   localparam logic [7:0] DUTY_RST = 8'h00;

endpackage

// ===== rtl/lbpb_string.sv
// One LED string: duty dimming, current code ramping and sink drive
`timescale 1ns/10ps
module lbpb_string #(
   parameter int unsigned DW = 7,
   parameter int unsigned CW = 8
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ms_tick,
   input wire logic dim_tick,
   input wire logic [DW-1:0] pwm_count,
   input wire logic [DW-1:0] duty_target,
   input wire logic dim_en,
   input wire logic [CW-1:0] code_target,
   input wire logic ramp_en,
   input wire logic [CW-1:0] idle_code,
   input wire logic current_ctrl,
   output logic sink_on,
   output logic [CW-1:0] sink_code,
   output logic [DW-1:0] duty_now
);
   import lbpb_pkg::*;

   localparam logic [DW-1:0] FULL_LIMIT = DW'(PWM_PERIOD);

   logic [DW-1:0] duty_q, duty_d;
   logic [CW-1:0] code_q, code_d;
   logic on_q, on_d;
   logic [CW-1:0] out_q, out_d;

   always_comb begin
      duty_d = duty_q;
      code_d = code_q;
      if (!dim_en) begin
         duty_d = duty_target;
      end else if (dim_tick) begin
         if (duty_q < duty_target) begin
            duty_d = duty_q + DW'(1);
         end else if (duty_q > duty_target) begin
            duty_d = duty_q - DW'(1);
         end
      end
      if (!ramp_en) begin
         code_d = code_target;
      end else if (ms_tick) begin
         if (code_q < code_target) begin
            code_d = code_q + CW'(1);
         end else if (code_q > code_target) begin
            code_d = code_q - CW'(1);
         end
      end
      // Above the period the switch stays closed; count below ratio is active
      on_d = (duty_q > FULL_LIMIT) || (pwm_count < duty_q);
      if (!current_ctrl) begin
         out_d = '0;
      end else if (on_d) begin
         out_d = code_q;
      end else begin
         out_d = idle_code;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         duty_q <= '0;
         code_q <= '0;
         on_q <= 1'b0;
         out_q <= '0;
      end else begin
         duty_q <= duty_d;
         code_q <= code_d;
         on_q <= on_d;
         out_q <= out_d;
      end
   end

   assign sink_on = on_q;
   assign sink_code = out_q;
   assign duty_now = duty_q;

endmodule

// ===== rtl/lbpb_top.sv
// LED backlight PWM generators, current codes and boost control with APB registers
`timescale 1ns/10ps
//
// Overview of operation
// - PWM period is 95 steps of the 2 MHz clock, about 21 kHz.
// - Ratio above 95 keeps the string switch closed continuously.
// - During the active part each sink except PWM-only string 3 drives its own current code.
// - During the inactive part all strings except PWM-only string 3 use the shared idle code.
// - With dimming enabled, ratio moves toward new value one step per 40 ms.
// - With dimming off, a new ratio applies at once.
// - Each string current is an 8-bit logarithmic code of 256 steps.
// - Per-string ramp enable moves current code one step per 1 ms.
// - String 3 PWM-only mode: no current, 0-100 % duty, no feedback.
// - Boost switches off on overvoltage or inductor overcurrent.
// - Bits 1..3 include the matching string input in boost feedback.
// - Bit 4 selects current limit: 710 mA clear, 1000 mA set.
// - Bit 5 selects 1 MHz clear or 2 MHz set; resets to 1.
// - Bit 6 set masks boost fault from the interrupt request.
// - Write-one-to-clear bit 7 records an overvoltage or overcurrent fault event.
// - Fault event clears only on writing one; writing zero keeps it.
// - Clearing a sink enable also clears that string's feedback inclusion.
// - Each ratio is a 7-bit count of 2 MHz periods, zero is off.
module lbpb_top #(
   parameter int unsigned RAMP_CYC = lbpb_pkg::CUR_RAMP_CYC,
   parameter int unsigned DIM_CYC = lbpb_pkg::DIM_STEP_CYC
) (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lbpb_pkg::PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic overvoltage_detect,
   input wire logic overcurrent_detect,
   output logic boost_switch_enable,
   output logic step_up_current_limit_sel,
   output logic step_up_switch_freq_sel,
   output logic string1_feedback_include,
   output logic string2_feedback_include,
   output logic string3_feedback_include,
   output logic string1_sink_enable,
   output logic string2_sink_enable,
   output logic string3_sink_enable,
   output logic string1_sink_on,
   output logic string2_sink_on,
   output logic string3_sink_on,
   output logic [lbpb_pkg::CODE_W-1:0] string1_sink_code,
   output logic [lbpb_pkg::CODE_W-1:0] string2_sink_code,
   output logic [lbpb_pkg::CODE_W-1:0] string3_sink_code,
   output logic interrupt_request_n
);
   import lbpb_pkg::*;

   localparam int unsigned DIV_W = $clog2(STEP_DIV);
   localparam int unsigned RAMP_W = $clog2(RAMP_CYC + 1);
   localparam int unsigned DIM_W = $clog2(DIM_CYC + 1);

   ////////////////////////////////////////////////////////////////////////////
   // Time bases

   logic [DIV_W-1:0] div_q, div_d;
   logic [DUTY_W-1:0] pwm_q, pwm_d;
   logic [RAMP_W-1:0] ms_q, ms_d;
   logic [DIM_W-1:0] dim_q, dim_d;
   logic step_en, ms_tick, dim_tick;

   always_comb begin
      step_en = (div_q == DIV_W'(STEP_DIV - 1));
      ms_tick = (ms_q == RAMP_W'(RAMP_CYC - 1));
      dim_tick = (dim_q == DIM_W'(DIM_CYC - 1));
      div_d = step_en ? '0 : div_q + DIV_W'(1);
      ms_d = ms_tick ? '0 : ms_q + RAMP_W'(1);
      dim_d = dim_tick ? '0 : dim_q + DIM_W'(1);
      pwm_d = pwm_q;
      if (step_en) begin
         pwm_d = (pwm_q == DUTY_W'(PWM_PERIOD - 1)) ? '0 : pwm_q + DUTY_W'(1);
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         div_q <= '0;
         pwm_q <= '0;
         ms_q <= '0;
         dim_q <= '0;
      end else begin
         div_q <= div_d;
         pwm_q <= pwm_d;
         ms_q <= ms_d;
         dim_q <= dim_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // APB slave, one wait state so read data leave a flip-flop

   logic rdy_q, rdy_d;
   logic err_q, err_d;
   logic [31:0] rdata_q, rdata_d;
   logic [7:0] boost_q, boost_d;
   logic [7:0] ledc_q, ledc_d;
   logic [7:0] idle_q, idle_d;
   logic [7:0] code_q [3], code_d [3];
   logic [7:0] duty_q [3], duty_d [3];
   logic [7:0] rd_idx;
   logic [7:0] rd_val;
   logic hit;
   logic wr_now;
   logic fault_now;
   logic [DUTY_W-1:0] duty_now [3];

   assign rd_idx = paddr[9:2];
   assign wr_now = psel && penable && rdy_q && pwrite && !err_q;
   assign fault_now = overvoltage_detect || overcurrent_detect;

   always_comb begin
      hit = 1'b1;
      rd_val = 8'h00;
      unique case (rd_idx)
         REG_BOOST: rd_val = boost_q;
         REG_LED_CONTROL: rd_val = ledc_q;
         REG_IDLE_CURRENT: rd_val = idle_q;
         REG_STRING1_CURRENT: rd_val = code_q[0];
         REG_STRING1_CURRENT + 8'h01: rd_val = code_q[1];
         REG_STRING1_CURRENT + 8'h02: rd_val = code_q[2];
         REG_STRING1_DUTY: rd_val = duty_q[0];
         REG_STRING1_DUTY + 8'h01: rd_val = duty_q[1];
         REG_STRING1_DUTY + 8'h02: rd_val = duty_q[2];
         default: hit = 1'b0;
      endcase
      if (paddr[1:0] != 2'b00 || paddr[PADDR_W-1:10] != '0) begin
         hit = 1'b0;
      end
      rdy_d = psel && penable && !rdy_q;
      err_d = rdy_q ? err_q : !hit;
      rdata_d = rdata_q;
      if (psel && penable && !rdy_q) begin
         rdata_d = (hit && !pwrite) ? {24'h000000, rd_val} : 32'h00000000;
      end
   end

   always_comb begin
      boost_d = boost_q;
      ledc_d = ledc_q;
      idle_d = idle_q;
      code_d = code_q;
      duty_d = duty_q;
      if (wr_now) begin
         unique case (rd_idx)
            REG_BOOST: begin
               boost_d[BST_MASK:0] = pwdata[BST_MASK:0];
               if (pwdata[BST_EVENT]) begin
                  boost_d[BST_EVENT] = 1'b0;
               end
            end
            REG_LED_CONTROL: ledc_d = {1'b0, pwdata[6:0]};
            REG_IDLE_CURRENT: idle_d = pwdata[7:0];
            REG_STRING1_CURRENT: code_d[0] = pwdata[7:0];
            REG_STRING1_CURRENT + 8'h01: code_d[1] = pwdata[7:0];
            REG_STRING1_CURRENT + 8'h02: code_d[2] = pwdata[7:0];
            REG_STRING1_DUTY: duty_d[0] = pwdata[7:0];
            REG_STRING1_DUTY + 8'h01: duty_d[1] = pwdata[7:0];
            REG_STRING1_DUTY + 8'h02: duty_d[2] = pwdata[7:0];
            default: ;
         endcase
      end
      // PWM-only string 3 loses its sink enable and feedback inclusion
      if (!ledc_d[LEDC_ICONT3]) begin
         ledc_d[4] = 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
         if (!ledc_d[2 * i]) begin
            boost_d[BST_FB1 + i] = 1'b0;
         end
      end
      // A fault in the clearing cycle still leaves the event set
      if (fault_now) begin
         boost_d[BST_EVENT] = 1'b1;
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         rdy_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= 32'h00000000;
         boost_q <= BOOST_RST;
         ledc_q <= LED_CONTROL_RST;
         idle_q <= CODE_RST;
         for (int i = 0; i < 3; i++) begin
            code_q[i] <= CODE_RST;
            duty_q[i] <= DUTY_RST;
         end
      end else begin
         rdy_q <= rdy_d;
         err_q <= err_d;
         rdata_q <= rdata_d;
         boost_q <= boost_d;
         ledc_q <= ledc_d;
         idle_q <= idle_d;
         code_q <= code_d;
         duty_q <= duty_d;
      end
   end

   assign pready = rdy_q;
   assign pslverr = rdy_q && err_q;
   assign prdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // Strings

   logic sink_on [3];
   logic [CODE_W-1:0] sink_code [3];

   for (genvar g = 0; g < 3; g++) begin : g_str
      lbpb_string #(
         .DW(DUTY_W),
         .CW(CODE_W)
      ) u_str (
         .mclk(mclk),
         .sys_rst(sys_rst),
         .ms_tick(ms_tick),
         .dim_tick(dim_tick),
         .pwm_count(pwm_q),
         .duty_target(duty_q[g][DUTY_W-1:0]),
         .dim_en(duty_q[g][DUTY_DIM]),
         .code_target(code_q[g]),
         .ramp_en(ledc_q[2 * g + 1]),
         .idle_code(idle_q),
         .current_ctrl((g != 2) || ledc_q[LEDC_ICONT3]),
         .sink_on(sink_on[g]),
         .sink_code(sink_code[g]),
         .duty_now(duty_now[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Boost and sink outputs

   // Comparators act at once, so the switch drops in the same cycle
   assign boost_switch_enable = boost_q[BST_EN] && !fault_now;
   assign step_up_current_limit_sel = boost_q[BST_ILIM];
   assign step_up_switch_freq_sel = boost_q[BST_FREQ];
   assign string1_feedback_include = boost_q[BST_FB1];
   assign string2_feedback_include = boost_q[BST_FB1 + 1];
   assign string3_feedback_include = boost_q[BST_FB1 + 2];
   assign interrupt_request_n = !(boost_q[BST_EVENT] && !boost_q[BST_MASK]);
   assign string1_sink_enable = ledc_q[0];
   assign string2_sink_enable = ledc_q[2];
   assign string3_sink_enable = ledc_q[4];
   assign string1_sink_on = sink_on[0];
   assign string2_sink_on = sink_on[1];
   assign string3_sink_on = sink_on[2];
   assign string1_sink_code = sink_code[0];
   assign string2_sink_code = sink_code[1];
   assign string3_sink_code = sink_code[2];

endmodule
